// file: design/lls_consts.svh
// constants for the line load shedder: offsets, fields, reset values, timing
`ifndef LLS_CONSTS_SVH
`define LLS_CONSTS_SVH

// ****************************************
// timing
// ****************************************
`define LLS_CLK_PERIOD_NS 10
`define LLS_NS_PER_S 1000000000
`define LLS_CYC_PER_S (`LLS_NS_PER_S / `LLS_CLK_PERIOD_NS)
`define LLS_TEST_PERIOD_S 4
`define LLS_FAIL_S 3
`define LLS_EXT_S 8
`define LLS_EXT_MAX_S (`LLS_FAIL_S + `LLS_EXT_S)
`define LLS_BLOCK_MIN 3
`define LLS_S_PER_MIN 60
`define LLS_BLOCK_S (`LLS_BLOCK_MIN * `LLS_S_PER_MIN)
`define LLS_RUN_LIMIT 3
`define LLS_MAX_REDUCTIONS 4

// ****************************************
// groups and reset values
// ****************************************
`define LLS_GROUPS 16
`define LLS_FRAC_DEN 16
`define LLS_RST_FRAC 1

// ****************************************
// register offsets (byte addresses) and fields
// ****************************************
`define LLS_OFS_CMD 8'h00
`define LLS_OFS_STATUS 8'h04
`define LLS_OFS_MASK 8'h08
`define LLS_OFS_EXCEED3 8'h0c
`define LLS_OFS_EXCEED11 8'h10
`define LLS_CMD_INHIBIT 4'h1
`define LLS_CMD_MANUAL_ON 4'h2
`define LLS_CMD_AUTOMATIC 4'h3
`define LLS_CMD_MASK_PRINT 4'h4
`define LLS_ST_MODE_LSB 0
`define LLS_ST_ENABLED 2
`define LLS_ST_ACTIVE 3
`define LLS_ST_RED_LSB 4
`define LLS_ST_LAMP 7

`endif

// file: design/lls_order_mem.sv
// small memory of denied group numbers, read data registered
`timescale 1ns/1ps
module lls_order_mem #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned WIDTH = 4
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  import lls_pkg::*;

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule // lls_order_mem

// file: design/lls_pkg.sv
// types shared by the line load shedder modules
package lls_pkg;

  typedef enum logic [1:0]
  {
    LLS_MODE_OFF = 2'h0,
    LLS_MODE_AUTO = 2'h1,
    LLS_MODE_ON = 2'h3
  } lls_mode_e;

  typedef enum logic [1:0]
  {
    LLS_T_IDLE = 2'h0,
    LLS_T_BASE = 2'h1,
    LLS_T_EXT = 2'h3
  } lls_test_e;

endpackage

// file: design/lls_tick_div.sv
// one-cycle enable pulse once per programmable number of clock cycles
`timescale 1ns/1ps
module lls_tick_div #(
  parameter int unsigned CYCLES = 100000000
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  import lls_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } lls_div_s;

  lls_div_s st_reg;
  lls_div_s st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == 32'(CYCLES - 1))
    begin
      st_next.cnt = 32'h0;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign tick = st_reg.tick;
endmodule // lls_tick_div

// file: design/lls_top.sv
// line load shedder: modes, speed tests, blockage, group denial, avalon slave
`timescale 1ns/1ps
`include "lls_consts.svh"
module lls_top #(
  parameter int unsigned NGROUPS = `LLS_GROUPS,
  parameter int unsigned ESS_FRAC = `LLS_RST_FRAC,
  parameter lls_pkg::lls_mode_e REINIT_MODE = lls_pkg::LLS_MODE_OFF,
  parameter int unsigned CYC_PER_S = `LLS_CYC_PER_S
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic dial_tone_seen,
  input wire logic blockage_high,
  input wire logic tests_inhibited,
  output logic speed_test_start,
  output lls_pkg::lls_mode_e mode,
  output logic shedder_enabled_lamp,
  output logic tone_delay_lamp,
  output logic major_alarm,
  output logic serious_status_report,
  output logic minor_status_report,
  output logic shed_change_report,
  output logic mask_report,
  output logic [NGROUPS-1:0] group_denied
);
  import lls_pkg::*;

  localparam int unsigned IW = $clog2(NGROUPS);
  localparam int unsigned CW = IW + 1;
  localparam int unsigned ESS_N = ESS_FRAC * NGROUPS / `LLS_FRAC_DEN;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    lls_mode_e mode;
    logic enabled;
    logic [NGROUPS-1:0] mask;
    logic [IW-1:0] head;
    logic [IW-1:0] tail;
    logic [CW-1:0] denied;
    logic [CW-1:0] pend;
    logic [2:0] reductions;
    logic busy;
    lls_test_e test;
    logic [3:0] elapsed;
    logic [2:0] period;
    logic [7:0] blk_sec;
    logic hold;
    logic [1:0] fail_run;
    logic [1:0] ext_run;
    logic [15:0] exceed3;
    logic [15:0] exceed11;
    logic fail_flag;
    logic tone_lamp;
    logic alarm;
    logic serious;
    logic minor;
    logic shed_chg;
    logic mask_rep;
    logic test_start;
    logic [1:0] s_tone;
    logic [1:0] s_blk;
    logic [1:0] s_tinh;
    logic wait_n;
    logic [31:0] rdata;
  } lls_state_s;

  lls_state_s st_reg;
  lls_state_s st_next;
  logic sec_tick;
  logic mem_we;
  logic [IW-1:0] mem_wdata;
  logic [IW-1:0] mem_rdata;
  logic ev_pass;
  logic ev_fail3;
  logic ev_fail11;
  logic trig;
  logic ack_wr;
  logic [3:0] cmd;
  logic [CW-1:0] served;
  logic [IW-1:0] cand;
  logic cand_ok;

  // ****************************************
  // helpers
  // ****************************************
  // nonessential groups still allowed to originate
  function automatic logic [CW-1:0] count_served(input logic [NGROUPS-1:0] m);
    logic [CW-1:0] c;
    c = '0;
    for (int i = ESS_N; i < NGROUPS; i++)
      if (!m[i])
        c = c + CW'(1);
    return c;
  endfunction

  // essential groups sit at the low indices and are never picked
  function automatic logic [IW:0] first_served(input logic [NGROUPS-1:0] m);
    logic [IW:0] r;
    r = '0;
    for (int i = NGROUPS - 1; i >= int'(ESS_N); i--)
      if (!m[i])
        r = {1'b1, IW'(i)};
    return r;
  endfunction

  function automatic lls_state_s clear_shed(input lls_state_s s);
    lls_state_s r;
    r = s;
    r.mask = '0;
    r.head = '0;
    r.tail = '0;
    r.denied = '0;
    r.pend = '0;
    r.busy = 1'b0;
    r.reductions = '0;
    r.hold = 1'b0;
    return r;
  endfunction

  lls_tick_div #(
    .CYCLES(CYC_PER_S)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .tick(sec_tick)
  );

  lls_order_mem #(
    .DEPTH(NGROUPS),
    .WIDTH(IW)
  ) u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(st_reg.tail),
    .wdata(mem_wdata),
    .raddr(st_reg.head),
    .rdata(mem_rdata)
  );

  assign served = count_served(st_reg.mask);
  assign {cand_ok, cand} = first_served(st_reg.mask);
  assign mem_wdata = cand;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_next = st_reg;
    mem_we = 1'b0;
    ev_pass = 1'b0;
    ev_fail3 = 1'b0;
    ev_fail11 = 1'b0;
    trig = 1'b0;
    st_next.alarm = 1'b0;
    st_next.serious = 1'b0;
    st_next.minor = 1'b0;
    st_next.shed_chg = 1'b0;
    st_next.mask_rep = 1'b0;
    st_next.test_start = 1'b0;
    st_next.s_tone = {st_reg.s_tone[0], dial_tone_seen};
    st_next.s_blk = {st_reg.s_blk[0], blockage_high};
    st_next.s_tinh = {st_reg.s_tinh[0], tests_inhibited};

    // speed test: 3 s base, extended up to 8 s more
    if (sec_tick)
      st_next.period = (st_reg.period == 3'(`LLS_TEST_PERIOD_S - 1)) ? 3'h0
                                                                   : st_reg.period + 3'h1;
    unique case (st_reg.test)
      LLS_T_IDLE:
      begin
        if (sec_tick && st_reg.period == 3'h0 && st_reg.mode != LLS_MODE_OFF)
        begin
          st_next.test = LLS_T_BASE;
          st_next.elapsed = 4'h0;
          st_next.test_start = 1'b1;
        end
      end
      LLS_T_BASE:
      begin
        if (st_reg.s_tone[1])
        begin
          ev_pass = 1'b1;
          st_next.ext_run = 2'h0;
          st_next.test = LLS_T_IDLE;
        end
        else if (sec_tick && st_reg.elapsed == 4'(`LLS_FAIL_S - 1))
        begin
          ev_fail3 = 1'b1;
          st_next.test = LLS_T_EXT;
          st_next.elapsed = st_reg.elapsed + 4'h1;
        end
        else if (sec_tick)
          st_next.elapsed = st_reg.elapsed + 4'h1;
      end
      LLS_T_EXT:
      begin
        if (st_reg.s_tone[1])
        begin
          st_next.ext_run = 2'h0;
          st_next.test = LLS_T_IDLE;
        end
        else if (sec_tick && st_reg.elapsed == 4'(`LLS_EXT_MAX_S - 1))
        begin
          ev_fail11 = 1'b1;
          st_next.test = LLS_T_IDLE;
        end
        else if (sec_tick)
          st_next.elapsed = st_reg.elapsed + 4'h1;
      end
      default:
        st_next.test = LLS_T_IDLE;
    endcase
    if (st_reg.mode == LLS_MODE_OFF || st_reg.s_tinh[1])
      st_next.test = LLS_T_IDLE;

    // traffic counts wrap silently; software reads them as deltas
    if (ev_fail3)
      st_next.exceed3 = st_reg.exceed3 + 16'h1;
    if (ev_fail11)
      st_next.exceed11 = st_reg.exceed11 + 16'h1;

    // consecutive base failures
    if (ev_pass)
      st_next.fail_run = 2'h0;
    else if (ev_fail3 && st_reg.fail_run == 2'(`LLS_RUN_LIMIT - 1))
    begin
      st_next.fail_run = 2'h0;
      trig = 1'b1;
    end
    else if (ev_fail3)
      st_next.fail_run = st_reg.fail_run + 2'h1;

    // automatic enable on extended failures
    if (ev_fail11 && st_reg.ext_run == 2'(`LLS_RUN_LIMIT - 1))
    begin
      st_next.ext_run = 2'h0;
      if (st_reg.mode == LLS_MODE_AUTO && !st_reg.enabled)
      begin
        st_next.enabled = 1'b1;
        st_next.alarm = 1'b1;
        st_next.serious = 1'b1;
      end
    end
    else if (ev_fail11)
      st_next.ext_run = st_reg.ext_run + 2'h1;

    // blockage sampled once per interval; a blockage denial holds restores
    if (sec_tick && st_reg.blk_sec == 8'(`LLS_BLOCK_S - 1))
    begin
      st_next.blk_sec = 8'h0;
      st_next.hold = st_reg.enabled && st_reg.s_blk[1];
      if (st_reg.enabled && st_reg.s_blk[1])
        trig = 1'b1;
    end
    else if (sec_tick)
      st_next.blk_sec = st_reg.blk_sec + 8'h1;

    // halve served groups; fourth reduction takes all
    if (trig && st_reg.enabled && st_reg.pend == '0 && served != '0)
    begin
      if (st_reg.reductions >= 3'(`LLS_MAX_REDUCTIONS - 1))
        st_next.pend = served;
      else
        st_next.pend = served - (served >> 1);
      if (st_reg.reductions != 3'(`LLS_MAX_REDUCTIONS))
        st_next.reductions = st_reg.reductions + 3'h1;
      if (st_reg.denied == '0)
        st_next.shed_chg = 1'b1;
    end

    // one group a cycle, its number logged for oldest-first restore
    if (st_reg.pend != '0)
    begin
      if (cand_ok)
      begin
        st_next.mask[cand] = 1'b1;
        mem_we = 1'b1;
        st_next.tail = st_reg.tail + IW'(1);
        st_next.denied = st_reg.denied + CW'(1);
        st_next.pend = st_reg.pend - CW'(1);
      end
      else
        st_next.pend = '0;
    end

    // restore the oldest denied group per passed
    if (ev_pass && !st_reg.hold && st_reg.denied != '0 && st_reg.pend == '0 && !st_reg.busy)
      st_next.busy = 1'b1;
    if (st_reg.busy)
    begin
      st_next.busy = 1'b0;
      st_next.mask[mem_rdata] = 1'b0;
      st_next.head = st_reg.head + IW'(1);
      // a denial step may land in this cycle too, so count from st_next
      st_next.denied = st_next.denied - CW'(1);
      if (st_next.denied == '0)
      begin
        st_next.shed_chg = 1'b1;
        st_next.reductions = 3'h0;
      end
    end

    // automatic self-disable once restored and passing
    if (st_reg.mode == LLS_MODE_AUTO && st_reg.enabled && ev_pass && st_reg.denied == '0 &&
        st_reg.pend == '0 && !st_reg.hold && !st_reg.s_blk[1])
      st_next.enabled = 1'b0;

    // testing inhibited clears all denials as inhibit does, but keeps mode and enable
    if (st_reg.s_tinh[1])
      st_next = clear_shed(st_next);

    if (ev_fail3)
      st_next.fail_flag = 1'b1;
    else if (ev_pass)
      st_next.fail_flag = 1'b0;

    // ****************************************
    // avalon slave: one wait state per access
    // ****************************************
    ack_wr = avs_write && !st_reg.wait_n;
    cmd = avs_writedata[3:0];
    st_next.wait_n = !((avs_read || avs_write) && st_reg.wait_n);
    if (avs_read && st_reg.wait_n)
    begin
      unique case (avs_address)
        `LLS_OFS_CMD:
          st_next.rdata = {30'h0, st_reg.mode};
        `LLS_OFS_STATUS:
          st_next.rdata = {24'h0, st_reg.tone_lamp, st_reg.reductions,
                           st_reg.denied != '0, st_reg.enabled, st_reg.mode};
        `LLS_OFS_MASK:
          st_next.rdata = 32'(st_reg.mask);
        `LLS_OFS_EXCEED3:
          st_next.rdata = {16'h0, st_reg.exceed3};
        `LLS_OFS_EXCEED11:
          st_next.rdata = {16'h0, st_reg.exceed11};
        default:
          st_next.rdata = 32'h0;
      endcase
    end

    // commands override same-cycle internal decisions
    if (ack_wr && avs_address == `LLS_OFS_CMD)
    begin
      unique case (cmd)
        `LLS_CMD_INHIBIT:
        begin
          st_next = clear_shed(st_next);
          st_next.mode = LLS_MODE_OFF;
          st_next.enabled = 1'b0;
          st_next.minor = 1'b1;
          st_next.shed_chg = st_reg.denied != '0;
        end
        `LLS_CMD_MANUAL_ON:
        begin
          st_next.mode = LLS_MODE_ON;
          st_next.enabled = 1'b1;
          st_next.alarm = 1'b1;
          st_next.serious = 1'b1;
        end
        `LLS_CMD_AUTOMATIC:
        begin
          st_next.mode = LLS_MODE_AUTO;
          st_next.minor = 1'b1;
          // failures before the command do not count toward self-enable
          st_next.ext_run = 2'h0;
        end
        `LLS_CMD_MASK_PRINT:
          st_next.mask_rep = 1'b1;
        default:
        begin
        end
      endcase
    end

    // lamp also covers a failure seen this very cycle
    st_next.tone_lamp = st_next.fail_flag || (st_next.mask != '0);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.mode <= REINIT_MODE;
      st_reg.enabled <= (REINIT_MODE == LLS_MODE_ON);
      st_reg.wait_n <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = st_reg.wait_n;
  assign speed_test_start = st_reg.test_start;
  assign mode = st_reg.mode;
  assign shedder_enabled_lamp = st_reg.enabled;
  assign tone_delay_lamp = st_reg.tone_lamp;
  assign major_alarm = st_reg.alarm;
  assign serious_status_report = st_reg.serious;
  assign minor_status_report = st_reg.minor;
  assign shed_change_report = st_reg.shed_chg;
  assign mask_report = st_reg.mask_rep;
  assign group_denied = st_reg.mask;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cmd(logic [3:0] c);
    avs_write && !st_reg.wait_n && avs_address == `LLS_OFS_CMD && avs_writedata[3:0] == c;
  endsequence

  chk_off_no_deny: assert property (st_reg.mode == LLS_MODE_OFF |->
      st_reg.mask == '0)
    else $error("groups denied in off mode");
  chk_deny_needs_enable: assert property (st_reg.mask != '0 |-> st_reg.enabled)
    else $error("groups denied while disabled");
  chk_manual_on_seq: assert property (s_cmd(`LLS_CMD_MANUAL_ON) |=>
      st_reg.enabled && st_reg.alarm && st_reg.serious && st_reg.mode == LLS_MODE_ON)
    else $error("manual on did not enable with alarm and report");
  chk_inhibit_clears: assert property (s_cmd(`LLS_CMD_INHIBIT) |=>
      st_reg.mask == '0 && st_reg.minor && !st_reg.enabled)
    else $error("inhibit did not restore all groups");
  chk_exceed3_count: assert property (ev_fail3 |=>
      st_reg.exceed3 == $past(st_reg.exceed3) + 16'h1)
    else $error("base failure not counted");
  chk_halving_amount: assert property (trig && st_reg.enabled && st_reg.pend == '0 &&
      served != '0 && st_reg.reductions < 3'h3 && !st_reg.s_tinh[1] && !ack_wr |=>
      st_reg.pend == $past(served) - ($past(served) >> 1))
    else $error("wrong number of groups queued for denial");
  chk_oldest_restore: assert property (st_reg.busy && !st_reg.s_tinh[1] && !ack_wr |=>
      !st_reg.mask[$past(mem_rdata)] && st_reg.denied == $past(st_reg.denied) - CW'(1) +
      CW'($past(st_reg.pend != '0 && cand_ok)))
    else $error("oldest group not restored");
  chk_first_report: assert property ($rose(st_reg.mask != '0) |->
      $past(st_reg.shed_chg, 1))
    else $error("first denial without change report");
  chk_ext_ceiling: assert property (ev_fail11 |->
      st_reg.elapsed == 4'(`LLS_EXT_MAX_S - 1) && st_reg.fail_flag)
    else $error("extended failure not at ceiling");
  chk_lamp_follows: assert property (st_reg.mask != '0 |-> st_reg.tone_lamp)
    else $error("delay lamp dark while denying");
endmodule // lls_top

// file: testbench/line_load_shedding_control_bench.sv
// self-checking bench for the line load shedder
`timescale 1ns/1ps
`include "lls_consts.svh"
`define CHK(a, b) \
  begin \
    total_checks++; \
    if ((a) !== (b)) \
    begin \
      n_fail++; \
      $display("Error at %0t: got %h expected %h", $time, a, b); \
    end \
  end
module line_load_shedding_control_bench;
  import lls_pkg::*;
  localparam int unsigned CPS = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h0;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] r;
  logic wreq, tone, st, lamp, lamp_q, dlamp, alm, ser, mnr, chg, msk;
  logic blk = 1'b0;
  logic tinh = 1'b0;
  logic [15:0] dly = 16'hffff;
  logic [15:0] den;
  logic [15:0] den_q;
  lls_mode_e md;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int n_st = 0, n_ser = 0, n_mnr = 0, n_chg = 0, n_msk = 0, n_alm = 0, n_dn = 0, n_lf = 0;
  int c1, c2;

  always #5 clk = ~clk;

  lls_top #(.CYC_PER_S(CPS)) uut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd_q),
    .avs_write(wr_q), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .dial_tone_seen(tone), .blockage_high(blk), .tests_inhibited(tinh),
    .speed_test_start(st), .mode(md), .shedder_enabled_lamp(lamp), .tone_delay_lamp(dlamp),
    .major_alarm(alm), .serious_status_report(ser), .minor_status_report(mnr),
    .shed_change_report(chg), .mask_report(msk), .group_denied(den));

  lls_line_model line (.clk(clk), .rst(rst), .speed_test_start(st), .delay_cyc(dly),
    .dial_tone_seen(tone));

  // pulses are one cycle wide, so counting them never misses one
  always @(posedge clk)
  begin
    n_st += st;
    n_ser += ser;
    n_mnr += mnr;
    n_chg += chg;
    n_msk += msk;
    n_alm += alm;
    n_dn += (den !== den_q);
    n_lf += (lamp_q && !lamp);
    den_q = den;
    lamp_q = lamp;
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr_q <= w;
    rd_q <= !w;
    @(posedge clk);
    while (wreq !== 1'b0)
      @(posedge clk);
    r = rdat;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
  endtask

  // bounded wait for a counter to move, then let the effect settle
  task automatic wch(ref int c, input int lim);
    int c0;
    c0 = c;
    while (c == c0 && lim > 0)
    begin
      @(posedge clk);
      lim--;
    end
    wt(20);
  endtask

  task automatic t_reset();
    `CHK(md, LLS_MODE_OFF)
    `CHK({lamp, wreq, den}, {2'b01, 16'h0})
    bus(1'b0, `LLS_OFS_STATUS, 32'h0);
    `CHK(r, 32'h0)
    bus(1'b0, 8'h20, 32'h0);
    `CHK(r, 32'h0)
    c1 = n_st;
    wt(300);
    `CHK({den, n_st - c1}, {16'h0, 32'h0})
    $display("reset and off test done");
  endtask

  task automatic t_on();
    c1 = n_ser;
    c2 = n_alm;
    bus(1'b1, `LLS_OFS_CMD, `LLS_CMD_MANUAL_ON);
    wt(4);
    `CHK(md, LLS_MODE_ON)
    `CHK({lamp, n_ser - c1, n_alm - c2}, {1'b1, 32'h1, 32'h1})
    $display("manual on test done");
  endtask

  task automatic t_halve();
    logic [15:0] m [4] = '{16'h01fe, 16'h1ffe, 16'h7ffe, 16'hfffe};
    c1 = n_chg;
    for (int i = 0; i < 4; i++)
    begin
      wch(n_dn, 1500);
      `CHK(den, m[i])
      bus(1'b0, `LLS_OFS_STATUS, 32'h0);
      `CHK(r[6:4], i[2:0] + 3'h1)
    end
    `CHK({n_chg - c1, dlamp}, {32'h1, 1'b1})
    c1 = n_msk;
    bus(1'b1, `LLS_OFS_CMD, `LLS_CMD_MASK_PRINT);
    wt(4);
    bus(1'b0, `LLS_OFS_MASK, 32'h0);
    `CHK({n_msk - c1, r[15:0]}, {32'h1, 16'hfffe})
    dly <= 16'h2;
    wch(n_st, 300);
    `CHK(den, 16'hfffc)
    bus(1'b0, `LLS_OFS_EXCEED3, 32'h0);
    `CHK(r, 32'hc)
    bus(1'b0, `LLS_OFS_EXCEED11, 32'h0);
    `CHK(r, 32'hc)
    wch(n_chg, 2000);
    `CHK({den, dlamp, lamp, md}, {16'h0, 1'b0, 1'b1, LLS_MODE_ON})
    $display("halving and restore test done");
  endtask

  task automatic t_block();
    blk <= 1'b1;
    wch(n_dn, 4000);
    `CHK(den, 16'h01fe)
    wch(n_st, 200);
    wch(n_st, 200);
    c1 = n_st;
    wt(800);
    `CHK(n_st - c1, 10)
    `CHK(den, 16'h01fe)
    blk <= 1'b0;
    wch(n_dn, 4000);
    `CHK(den, 16'h01fc)
    tinh <= 1'b1;
    wt(10);
    `CHK(den, 16'h0)
    tinh <= 1'b0;
    $display("blockage test done");
  endtask

  task automatic t_inhibit();
    dly <= 16'hffff;
    wch(n_dn, 2000);
    c1 = n_mnr;
    bus(1'b1, `LLS_OFS_CMD, `LLS_CMD_INHIBIT);
    wt(3);
    `CHK({den, lamp, md}, {16'h0, 1'b0, LLS_MODE_OFF})
    `CHK(n_mnr - c1, 1)
    c2 = n_st;
    wt(300);
    `CHK({den, n_st - c2}, {16'h0, 32'h0})
    $display("inhibit test done");
  endtask

  task automatic t_auto();
    c1 = n_mnr;
    bus(1'b1, `LLS_OFS_CMD, `LLS_CMD_AUTOMATIC);
    wt(4);
    `CHK({md, lamp, n_mnr - c1}, {LLS_MODE_AUTO, 1'b0, 32'h1})
    c2 = n_alm;
    c1 = cyc;
    wch(n_ser, 2000);
    `CHK({lamp, n_alm - c2, cyc - c1 > 600}, {1'b1, 32'h1, 1'b1})
    dly <= 16'h2;
    wch(n_lf, 3000);
    `CHK({lamp, md, den}, {1'b0, LLS_MODE_AUTO, 16'h0})
    $display("automatic test done");
  endtask

  initial
  begin
    wt(6);
    rst <= 1'b0;
    wt(1);
    t_reset();
    t_on();
    t_halve();
    t_block();
    t_inhibit();
    t_auto();
    print_verdict();
  end
endmodule // line_load_shedding_control_bench

// file: testbench/lls_line_model.sv
// far-side test line model: dial tone returns a set delay after each test start
`timescale 1ns/1ps
module lls_line_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic speed_test_start,
  input wire logic [15:0] delay_cyc,
  output logic dial_tone_seen
);
  logic [15:0] wait_reg;
  logic [15:0] dly_reg;
  // delay latched at start, so a slow test stays slow to its end
  always_ff @(posedge clk)
  begin
    if (rst || speed_test_start)
    begin
      wait_reg <= 16'h0;
      dly_reg <= delay_cyc;
    end
    else if (wait_reg != 16'hffff)
    begin
      wait_reg <= wait_reg + 16'h1;
    end
  end
  // tone answers a few cycles only, so a level left from one test
  // never reaches the next one through the design's synchroniser
  assign dial_tone_seen = !rst && (wait_reg >= dly_reg) && (wait_reg - dly_reg < 16'h4);
endmodule // lls_line_model
